/* bench/ssq_meas_model.sv */
`timescale 1ns/1ps
// ==========================================================
// Measurement side: answers each reading request after a
// short or long latency; data is only meaningful with done
module ssq_meas_model import ssq_pkg::*; #(
	parameter int RDG_W = 32,
	parameter logic [31:0] TAG = 32'h0
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic slow,
	input wire logic meas_req,
	input wire logic [CH_W-1:0] relay_ch,
	output logic meas_done,
	output logic [RDG_W-1:0] meas_data
);
	logic busy = 1'b0;
	logic [3:0] wait_c = 4'h0;
	logic [CH_W-1:0] ch = '0;
	initial meas_done = 1'b0;
	initial meas_data = '0;
	// Data toggles outside the done cycle so a stale sample shows
	always @(posedge aclk) begin
		meas_done <= 1'b0;
		meas_data <= ~meas_data;
		if (!aresetn) begin
			busy <= 1'b0;
		end else if (meas_req) begin
			busy <= 1'b1;
			ch <= relay_ch;
			wait_c <= slow ? 4'h9 : 4'h0;
		end else if (busy && wait_c == 4'h0) begin
			busy <= 1'b0;
			meas_done <= 1'b1;
			meas_data <= TAG | RDG_W'(ch);
		end else if (busy) begin
			wait_c <= wait_c - 4'h1;
		end
	end
endmodule

/* bench/ssq_top_asserts.sv */
`timescale 1ns/1ps
module ssq_top_asserts import ssq_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic trig_out,
	input wire logic meas_req,
	input wire logic [CH_W-1:0] relay_ch,
	input wire logic relay_close,
	input wire logic ref_junction,
	input wire logic iface_serial,
	input wire logic iface_parallel,
	input wire logic scpi_only
);
	// ==========================================================
	// Port relations, all in the one clock domain
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_trig_one_pulse: assert property (trig_out |=> !trig_out)
		else $error("output trigger longer than one cycle");
	a_meas_one_pulse: assert property (meas_req |=> !meas_req)
		else $error("reading request longer than one cycle");
	a_iface_only_one: assert property (iface_serial != iface_parallel)
		else $error("remote interfaces not exclusive");
	a_serial_scpi: assert property (scpi_only == iface_serial)
		else $error("language lock does not follow serial");
	a_ref_on_first: assert property (
		ref_junction |-> relay_ch == REF_CH)
		else $error("reference junction away from channel 1");
	// A closed relay never changes channel without opening first
	a_open_first: assert property (
		relay_close && $past(relay_close) |-> $stable(relay_ch))
		else $error("channel changed while relay closed");
	a_iface_by_write: assert property (
		$changed(iface_serial) |-> $rose(s_axi_bvalid))
		else $error("interface changed without a write");
	a_bresp_holds: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped early");
	a_rdata_holds: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped early");
	a_read_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered next cycle");
	c_trig: cover property (trig_out);
	c_ref: cover property (ref_junction);
	c_serial: cover property ($rose(iface_serial));
endmodule
bind ssq_top ssq_top_asserts u_chk (.aclk(aclk), .aresetn(aresetn),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.trig_out(trig_out), .meas_req(meas_req), .relay_ch(relay_ch),
	.relay_close(relay_close), .ref_junction(ref_junction),
	.iface_serial(iface_serial), .iface_parallel(iface_parallel),
	.scpi_only(scpi_only));

/* bench/ssq_top_test.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin errors++; \
	$display("[FAIL] t=%0t got %h exp %h", $time, (g), (e)); end end
module ssq_top_test import ssq_pkg::*; ;
	localparam logic [31:0] TAG = 32'hc0de0000;
	// Clock cycles per millisecond tick in simulation
	localparam int MS_SIM = 4;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, slow = 1'b0, trig_in = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, trig_out, meas_req;
	logic meas_done, relay_close, ref_junction;
	logic iface_serial, iface_parallel, scpi_only;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, meas_data, d;
	logic [1:0] r;
	logic [CH_W-1:0] relay_ch;
	logic [ADDR_W-1:0] bus_addr;
	int errors = 0, samples_checked = 0, cyc = 0, n_trig = 0, n_meas = 0;
	int last = 0, min_gap = 1000, saw_ref = 0;

	ssq_top #(.MS_DIV(MS_SIM)) DUT (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .trig_in(trig_in),
		.trig_out(trig_out), .meas_req(meas_req), .meas_done(meas_done),
		.meas_data(meas_data), .relay_ch(relay_ch), .relay_close(relay_close),
		.ref_junction(ref_junction), .iface_serial(iface_serial),
		.iface_parallel(iface_parallel), .scpi_only(scpi_only),
		.bus_addr(bus_addr));
	ssq_meas_model #(.TAG(TAG)) u_meas (.aclk(aclk), .aresetn(aresetn),
		.slow(slow), .meas_req(meas_req), .relay_ch(relay_ch),
		.meas_done(meas_done), .meas_data(meas_data));

	// ==========================================================
	// Clock, event counting and hang guard
	initial forever #12.5 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc++;
		// Mainframe trigger line pulses every 64 cycles, free running
		trig_in <= (cyc % 64) < 8;
		if (trig_out) n_trig++;
		if (ref_junction) saw_ref = 1;
		if (meas_req) begin
			if (n_meas > 0 && cyc - last < min_gap) min_gap = cyc - last;
			last = cyc;
			n_meas++;
		end
		if (cyc > 60000) begin
			errors++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		$display("checked %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	// ==========================================================
	// Register bus master; each channel released once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v,
		input logic [1:0] er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		`CHK(bresp, er)
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	function automatic logic [31:0] cfg(input logic [7:0] fl,
		input logic [3:0] f, input logic [3:0] l);
		return {16'h0, l, f, fl};
	endfunction

	// ==========================================================
	// Scenarios: configure, start, wait for idle, count events
	task automatic run(input logic [31:0] c, input logic [31:0] n,
		input logic [31:0] go, input int et, input int em, input int es);
		int k;
		k = 0;
		wr(SSQ_CFG, c, RESP_OKAY);
		wr(SSQ_COUNT, n, RESP_OKAY);
		n_trig = 0;
		n_meas = 0;
		min_gap = 1000;
		wr(SSQ_CTRL, go, RESP_OKAY);
		do begin
			rd(SSQ_STATUS);
			k++;
		end while (d[0] === 1'b1 && k < 3000);
		`CHK(n_trig, et)
		`CHK(n_meas, em)
		`CHK(d[18:8], es[10:0])
	endtask

	task automatic reset_values();
		`CHK({iface_parallel, bus_addr, scpi_only}, {1'b1, BUS_ADDR_RST, SERIAL_RST})
		rd(SSQ_CFG);
		`CHK(d[15:8], 8'ha1)
		rd(8'h40);
		`CHK({d, r}, {32'h0, RESP_DECERR})
		wr(SSQ_COUNT, 32'd2000, RESP_OKAY);
		rd(SSQ_COUNT);
		`CHK(d[10:0], MAX_RDG)
	endtask

	task automatic buffer_word(input logic [31:0] i, input logic [31:0] e);
		wr(SSQ_BUFIDX, i, RESP_OKAY);
		rd(SSQ_BUFDATA);
		`CHK(d, e)
	endtask

	task automatic iface_swap();
		wr(SSQ_IFACE, 32'h0501, RESP_OKAY);
		`CHK({iface_serial, iface_parallel, scpi_only, bus_addr}, 8'ha5)
		rd(SSQ_STATUS);
		`CHK(d[18:8], 11'h0)
		wr(SSQ_IFACE, 32'h1000, RESP_OKAY);
		`CHK({iface_serial, iface_parallel, bus_addr}, 7'h30)
	endtask

	task automatic halt_midway();
		int k;
		k = 0;
		slow <= 1'b1;
		wr(SSQ_CFG, cfg(8'h00, 4'h1, 4'h5), RESP_OKAY);
		wr(SSQ_COUNT, 32'd5, RESP_OKAY);
		n_meas = 0;
		wr(SSQ_CTRL, 32'h1, RESP_OKAY);
		while (n_meas == 0 && k < 200) begin
			@(posedge aclk);
			k++;
		end
		wr(SSQ_CTRL, 32'h4, RESP_OKAY);
		rd(SSQ_STATUS);
		`CHK({d[0], relay_close}, 2'b00)
		slow <= 1'b0;
	endtask

	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		reset_values();
		run(cfg(8'h00, 4'h2, 4'h4), 32'd3, 32'h1, 3, 3, 3);
		slow <= 1'b1;
		run(cfg(8'h00, 4'h1, 4'h3), 32'd5, 32'h2, 2, 6, 5);
		slow <= 1'b0;
		buffer_word(32'd4, TAG | 32'h2);
		run(cfg(8'h00, 4'h1, 4'ha), 32'd2, 32'h2, 1, 10, 2);
		iface_swap();
		// Delay long enough to stand out from the plain channel gap
		wr(SSQ_DELAY, 32'd3, RESP_OKAY);
		run(cfg(8'h04, 4'h1, 4'h3), 32'd3, 32'h2, 1, 3, 3);
		`CHK(min_gap >= 3 * MS_SIM, 1'b1)
		// Interval of 5 ms; one tick of slack as the divider runs free
		wr(SSQ_TIMER, 32'd5, RESP_OKAY);
		run(cfg(8'h02, 4'h1, 4'h3), 32'd3, 32'h1, 3, 3, 3);
		`CHK(min_gap >= 4 * MS_SIM, 1'b1)
		// Mainframe triggers: one event per pass, channels back to back
		run(cfg(8'h09, 4'h1, 4'h3), 32'd6, 32'h2, 2, 6, 6);
		`CHK(min_gap < 32, 1'b1)
		saw_ref = 0;
		run(cfg(8'h11, 4'h1, 4'h2), 32'd2, 32'h1, 2, 2, 2);
		`CHK({saw_ref[0], ref_junction}, 2'b10)
		halt_midway();
		wrap_up();
	end
endmodule

/* hw/ssq_pkg.sv */
package ssq_pkg;
	// ==========================================================
	// Register map (byte addresses)
	localparam logic [7:0] SSQ_CTRL = 8'h00;
	localparam logic [7:0] SSQ_CFG = 8'h04;
	localparam logic [7:0] SSQ_COUNT = 8'h08;
	localparam logic [7:0] SSQ_TIMER = 8'h0c;
	localparam logic [7:0] SSQ_DELAY = 8'h10;
	localparam logic [7:0] SSQ_IFACE = 8'h14;
	localparam logic [7:0] SSQ_STATUS = 8'h18;
	localparam logic [7:0] SSQ_BUFIDX = 8'h1c;
	localparam logic [7:0] SSQ_BUFDATA = 8'h20;
	// ==========================================================
	// Field positions
	localparam int CTRL_STEP = 0;
	localparam int CTRL_SCAN = 1;
	localparam int CTRL_HALT = 2;
	localparam int CTRL_CLR = 3;
	localparam int CFG_EXT = 0;
	localparam int CFG_TMR = 1;
	localparam int CFG_DLY = 2;
	localparam int CFG_XTRG = 3;
	localparam int CFG_TC = 4;
	localparam int CFG_FIRST = 8;
	localparam int CFG_LAST = 12;
	localparam int IF_SERIAL = 0;
	localparam int IF_ADDR = 8;
	// ==========================================================
	// Sizes and reset values
	localparam int CH_W = 4;
	localparam int CNT_W = 11;
	localparam int MS_W = 32;
	localparam int ADDR_W = 5;
	localparam logic [CNT_W-1:0] MAX_RDG = 11'h400;
	localparam logic [CNT_W-1:0] COUNT_RST = 11'h001;
	localparam logic [CH_W-1:0] FIRST_RST = 4'h1;
	localparam logic [CH_W-1:0] LAST_RST = 4'ha;
	localparam logic [CH_W-1:0] REF_CH = 4'h1;
	localparam logic [ADDR_W-1:0] BUS_ADDR_RST = 5'h10;
	localparam logic SERIAL_RST = 1'b0;
	// ==========================================================
	// Timing: interval and delay are counted in milliseconds
	localparam int CLK_PERIOD_NS = 25;
	localparam int MS_NS = 1000000;
	localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
	// ==========================================================
	// Bus answers
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_DECERR = 2'b11;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_WAIT = 3'b001,
		ST_OPEN = 3'b010,
		ST_CLOSE = 3'b011,
		ST_DELAY = 3'b100,
		ST_MEAS = 3'b101,
		ST_NEXT = 3'b110
	} ssq_state_e;
endpackage

/* hw/ssq_top.sv */
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module ssq_top import ssq_pkg::*; #(
	parameter int DEPTH = 1024,
	parameter int RDG_W = 32,
	parameter int MS_DIV = MS_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic trig_in,
	output logic trig_out,
	output logic meas_req,
	input wire logic meas_done,
	input wire logic [RDG_W-1:0] meas_data,
	output logic [CH_W-1:0] relay_ch,
	output logic relay_close,
	output logic ref_junction,
	output logic iface_serial,
	output logic iface_parallel,
	output logic scpi_only,
	output logic [ADDR_W-1:0] bus_addr
);
	localparam int IDX_W = $clog2(DEPTH);
	localparam int DIV_W = $clog2(MS_DIV + 1);

	typedef struct packed {
		logic aw_ok;
		logic [7:0] aw_addr;
		logic w_ok;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [15:0] cfg;
		logic [CNT_W-1:0] rdg_count;
		logic [MS_W-1:0] timer_ms;
		logic [MS_W-1:0] delay_ms;
		logic serial_sel;
		logic [ADDR_W-1:0] addr;
		logic [IDX_W-1:0] buf_idx;
		ssq_state_e st;
		logic scan_mode;
		logic first_evt;
		logic [CH_W-1:0] ch;
		logic relay_on;
		logic [CNT_W-1:0] taken;
		logic [CNT_W-1:0] stored;
		logic [CNT_W-1:0] passes;
		logic trig_out;
		logic meas_req;
		logic [DIV_W-1:0] div;
		logic ms_tick;
		logic [MS_W-1:0] dly_cnt;
		logic [MS_W-1:0] tmr_cnt;
		logic tmr_run;
		logic tmr_hit;
		logic tmr_armed;
		logic [2:0] sync;
		logic [DEPTH-1:0][RDG_W-1:0] rbuf;
	} ssq_state_s;

	ssq_state_s s;
	ssq_state_s next_s;
	ssq_state_s rst_s;

	// ==========================================================
	// Helpers
	// Merge byte lanes of a write into an old word
	function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
			input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Is the address one of the mapped words
	function automatic logic is_mapped(input logic [7:0] a);
		return (a[7:2] <= SSQ_BUFDATA[7:2]);
	endfunction

	// ==========================================================
	// Reset image
	always_comb begin
		rst_s = '0;
		rst_s.st = ST_IDLE;
		rst_s.cfg[CFG_FIRST +: CH_W] = FIRST_RST;
		rst_s.cfg[CFG_LAST +: CH_W] = LAST_RST;
		rst_s.rdg_count = COUNT_RST;
		rst_s.serial_sel = SERIAL_RST;
		rst_s.addr = BUS_ADDR_RST;
	end

	// ==========================================================
	// Next-state logic
	always_comb begin
		logic [31:0] wv;
		logic [31:0] rv;
		logic [CH_W-1:0] first_ch;
		logic [CH_W-1:0] last_ch;
		logic ext_type;
		logic evt;
		logic go_step;
		logic go_scan;
		logic halt;
		wv = '0;
		rv = '0;
		next_s = s;
		first_ch = s.cfg[CFG_FIRST +: CH_W];
		last_ch = s.cfg[CFG_LAST +: CH_W];
		ext_type = s.cfg[CFG_EXT];
		go_step = 1'b0;
		go_scan = 1'b0;
		halt = 1'b0;
		evt = 1'b0;
		next_s.trig_out = 1'b0;
		next_s.meas_req = 1'b0;
		// Trigger line from the mainframe is asynchronous
		next_s.sync = {s.sync[1:0], trig_in};

		// Millisecond enable pulse from the clock divider
		next_s.ms_tick = 1'b0;
		if (s.div == DIV_W'(MS_DIV - 1)) begin
			next_s.div = '0;
			next_s.ms_tick = 1'b1;
		end else begin
			next_s.div = s.div + 1'b1;
		end

		// Interval timer runs once armed and saturates on a hit
		if (s.tmr_run && s.ms_tick && !s.tmr_hit) begin
			next_s.tmr_cnt = s.tmr_cnt + 1'b1;
			if (s.tmr_cnt + 1'b1 >= s.timer_ms) begin
				next_s.tmr_hit = 1'b1;
			end
		end

		// ------------------------------------------------------
		// Register write, taken once address and data are both in
		if (s_axi_awvalid && s_axi_awready) begin
			next_s.aw_ok = 1'b1;
			next_s.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_s.w_ok = 1'b1;
			next_s.w_data = s_axi_wdata;
			next_s.w_strb = s_axi_wstrb;
		end
		if (s.bvalid && s_axi_bready) begin
			next_s.bvalid = 1'b0;
		end
		if (s.aw_ok && s.w_ok && !s.bvalid) begin
			next_s.aw_ok = 1'b0;
			next_s.w_ok = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = is_mapped(s.aw_addr) ? RESP_OKAY : RESP_DECERR;
			unique case ({s.aw_addr[7:2], 2'b00})
				SSQ_CTRL: begin
					wv = merge_strb('0, s.w_data, s.w_strb);
					go_step = wv[CTRL_STEP];
					go_scan = wv[CTRL_SCAN];
					halt = wv[CTRL_HALT];
					if (wv[CTRL_CLR]) begin
						next_s.stored = '0;
					end
				end
				SSQ_CFG: begin
					wv = merge_strb({16'h0000, s.cfg}, s.w_data, s.w_strb);
					next_s.cfg = wv[15:0];
				end
				SSQ_COUNT: begin
					wv = merge_strb({21'h0, s.rdg_count}, s.w_data,
						s.w_strb);
					// Larger counts are clipped to the buffer size
					next_s.rdg_count = (wv > 32'(MAX_RDG)) ? MAX_RDG :
						wv[CNT_W-1:0];
				end
				SSQ_TIMER: begin
					next_s.timer_ms = merge_strb(s.timer_ms, s.w_data,
						s.w_strb);
				end
				SSQ_DELAY: begin
					next_s.delay_ms = merge_strb(s.delay_ms, s.w_data,
						s.w_strb);
				end
				SSQ_IFACE: begin
					wv = merge_strb({19'h0, s.addr, 7'h00, s.serial_sel},
						s.w_data, s.w_strb);
					// Clearing the serial bit selects the parallel bus
					next_s.serial_sel = wv[IF_SERIAL];
					next_s.addr = wv[IF_ADDR +: ADDR_W];
					if (wv[IF_SERIAL] != s.serial_sel) begin
						next_s.stored = '0;
					end
				end
				SSQ_BUFIDX: begin
					wv = merge_strb(32'(s.buf_idx), s.w_data, s.w_strb);
					next_s.buf_idx = wv[IDX_W-1:0];
				end
				default: begin
				end
			endcase
		end

		// ------------------------------------------------------
		// Register read, answered one edge after the address
		if (s.rvalid && s_axi_rready) begin
			next_s.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			unique case ({s_axi_araddr[7:2], 2'b00})
				SSQ_CFG: rv = {16'h0000, s.cfg};
				SSQ_COUNT: rv = 32'(s.rdg_count);
				SSQ_TIMER: rv = s.timer_ms;
				SSQ_DELAY: rv = s.delay_ms;
				SSQ_IFACE: rv = {19'h0, s.addr, 7'h00, s.serial_sel};
				SSQ_STATUS: rv = {1'b0, s.passes, 1'b0, s.stored, s.ch,
					s.relay_on, ref_junction, s.scan_mode,
					(s.st != ST_IDLE)};
				SSQ_BUFIDX: rv = 32'(s.buf_idx);
				SSQ_BUFDATA: rv = 32'(s.rbuf[s.buf_idx]);
				default: rv = '0;
			endcase
			next_s.rvalid = 1'b1;
			next_s.rdata = rv;
			next_s.rresp = is_mapped(s_axi_araddr) ? RESP_OKAY :
				RESP_DECERR;
		end

		// ------------------------------------------------------
		// Start event: external line, timer or immediate
		if (s.cfg[CFG_XTRG]) begin
			evt = s.sync[1] && !s.sync[2];
		end else if (s.cfg[CFG_TMR]) begin
			evt = s.first_evt || s.tmr_hit;
		end else begin
			evt = 1'b1;
		end

		// Sequencer
		unique case (s.st)
			ST_IDLE: begin
				if (go_step || go_scan) begin
					next_s.st = ST_WAIT;
					next_s.scan_mode = go_scan;
					next_s.ch = first_ch;
					next_s.taken = '0;
					next_s.stored = '0;
					next_s.passes = '0;
					next_s.first_evt = 1'b1;
					next_s.tmr_run = 1'b0;
					next_s.tmr_hit = 1'b0;
				end
			end
			ST_WAIT: begin
				if (evt) begin
					next_s.first_evt = 1'b0;
					next_s.tmr_run = 1'b0;
					next_s.tmr_hit = 1'b0;
					next_s.tmr_cnt = '0;
					next_s.tmr_armed = 1'b0;
					next_s.st = ext_type ? ST_DELAY : ST_OPEN;
					next_s.dly_cnt = '0;
				end
			end
			ST_OPEN: begin
				// Break before make on the relay card
				next_s.relay_on = 1'b0;
				next_s.st = ST_CLOSE;
			end
			ST_CLOSE: begin
				next_s.relay_on = 1'b1;
				next_s.st = ST_DELAY;
				next_s.dly_cnt = '0;
			end
			ST_DELAY: begin
				// Manual delay before every reading; auto counts none
				if (s.cfg[CFG_DLY] && s.dly_cnt < s.delay_ms) begin
					if (s.ms_tick) begin
						next_s.dly_cnt = s.dly_cnt + 1'b1;
					end
				end else begin
					// Interval starts after the first delay of a pass
					if (s.cfg[CFG_TMR] && !s.tmr_armed) begin
						next_s.tmr_armed = 1'b1;
						next_s.tmr_run = 1'b1;
						next_s.tmr_cnt = '0;
						next_s.tmr_hit = (s.timer_ms == '0);
					end
					next_s.meas_req = 1'b1;
					next_s.st = ST_MEAS;
				end
			end
			ST_MEAS: begin
				if (meas_done) begin
					next_s.taken = s.taken + 1'b1;
					if (s.stored < s.rdg_count) begin
						next_s.rbuf[s.stored[IDX_W-1:0]] = meas_data;
						next_s.stored = s.stored + 1'b1;
					end
					next_s.st = ST_NEXT;
				end
			end
			ST_NEXT: begin
				// Open on the same edge as the channel number moves on, so the card
				// never sees a new channel with its relay still closed
				next_s.relay_on = 1'b0;
				if (!s.scan_mode) begin
					// One reading per trigger while stepping
					next_s.trig_out = 1'b1;
					next_s.ch = (s.ch == last_ch) ? first_ch :
						s.ch + 1'b1;
					next_s.st = (s.taken >= s.rdg_count) ? ST_IDLE :
						ST_WAIT;
				end else if (s.ch == last_ch) begin
					// Whole pass done; stop once enough readings taken
					next_s.trig_out = 1'b1;
					next_s.passes = s.passes + 1'b1;
					next_s.ch = first_ch;
					next_s.st = (s.taken >= s.rdg_count) ? ST_IDLE :
						ST_WAIT;
				end else begin
					// Inside a pass the event source is bypassed
					next_s.ch = s.ch + 1'b1;
					next_s.st = ext_type ? ST_DELAY : ST_OPEN;
					next_s.dly_cnt = '0;
				end
			end
			default: begin
				next_s.st = ST_IDLE;
			end
		endcase

		// Relays are left open whenever no operation runs
		if (next_s.st == ST_IDLE) begin
			next_s.relay_on = 1'b0;
		end

		// Halt wins over the sequencer's state, relay, timer, request and trigger
		if (halt) begin
			next_s.st = ST_IDLE;
			next_s.relay_on = 1'b0;
			next_s.tmr_run = 1'b0;
			next_s.meas_req = 1'b0;
			next_s.trig_out = 1'b0;
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= rst_s;
		end else begin
			s <= next_s;
		end
	end

	// ==========================================================
	// Outputs
	// Bus ready while the holding slot is free
	assign s_axi_awready = !s.aw_ok && !s.bvalid;
	assign s_axi_wready = !s.w_ok && !s.bvalid;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = s.bresp;
	assign s_axi_arready = !s.rvalid;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rdata = s.rdata;
	assign s_axi_rresp = s.rresp;
	// Sequencer outputs come straight from the state
	assign trig_out = s.trig_out;
	assign meas_req = s.meas_req;
	assign relay_ch = s.ch;
	assign relay_close = s.relay_on;
	// Reference junction only while a step or scan is running
	assign ref_junction = s.cfg[CFG_TC] && s.cfg[CFG_EXT] &&
		(s.st != ST_IDLE) && (s.ch == REF_CH);
	// One flag drives both, so exactly one is ever active
	assign iface_serial = s.serial_sel;
	assign iface_parallel = !s.serial_sel;
	assign scpi_only = s.serial_sel;
	assign bus_addr = s.addr;
endmodule
